// ===== src/spmp_top.sv
// Purpose: byte serial port, master or slave, APB register access
// Assumes: one clock; pins synchronous except in slave role
// Notes:   shifter shared by transmit and receive
// Notes on behaviour
// - master data write starts clock, eight bits, done
// - select input low as master: drop master, done
// - slave unselected: MISO off, edges ignored
// - selected slave shifts; done per byte
// - select rise resets counter, drops partial
// - full bytes to receive buffer; read it
// - setup and sample on opposite edges
// - mode field picks sample and setup edges
// - idle clock level follows polarity bit
// - prescaler and double speed divide clock
// - divider ignored in slave role
// - enable bit gates every transfer
// - order bit picks LSB or MSB first
// - request when done and level non-zero
// - done clears on ack or read sequence
// - write during shifting sets collision
// - collision clears by status then data
// - unused status bits read zero
// - pin direction overrides per role
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "spmp_consts.svh"
module spmp_top
	import spmp_pkg::*;
#(
	parameter int AW = 4
) (
	input  wire logic          core_clk,
	input  wire logic          resetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          sck_in,
	output logic               sck_out,
	output logic               sck_oe,
	input  wire logic          mosi_in,
	output logic               mosi_out,
	output logic               mosi_oe,
	input  wire logic          miso_in,
	output logic               miso_out,
	output logic               miso_oe,
	input  wire logic          ss_n_in,
	input  wire logic          ss_pin_is_input,
	input  wire logic          user_dir_sck,
	input  wire logic          user_dir_mosi,
	input  wire logic          user_dir_miso,
	input  wire logic          irq_ack,
	output logic               irq_req,
	output logic [1:0]         irq_level
);

	// ************************************************
	// State and synchronised pins
	// ************************************************
	spmp_state_s st_r;
	spmp_state_s st_nxt;

	logic [2:0] pin_s;
	logic       sck_s;
	logic       mosi_s;
	logic       ss_n_s;

	spmp_sync #(
		.W (3)
	) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.d        ({sck_in, mosi_in, ss_n_in}),
		.q        (pin_s)
	);

	assign sck_s  = pin_s[2];
	assign mosi_s = pin_s[1];
	assign ss_n_s = pin_s[0];

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic addr_hit(input logic [AW-1:0] a);
		addr_hit = (a[1:0] == 2'h0) && ((a >> 4) == {AW{1'b0}});
	endfunction

	function automatic logic [1:0] addr_idx(input logic [AW-1:0] a);
		addr_idx = a[3:2];
	endfunction

	// Bit that goes out next
	function automatic logic tx_bit(input logic [7:0] s,
	                                input logic       lsb_first);
		tx_bit = lsb_first ? s[0] : s[7];
	endfunction

	// Sampled bit enters at the end opposite the one the outgoing bit left
	function automatic logic [7:0] shift_in(input logic [7:0] s,
	                                        input logic       b,
	                                        input logic       lsb_first);
		shift_in = lsb_first ? {b, s[7:1]} : {s[6:0], b};
	endfunction

	// Half period reload in core cycles
	function automatic logic [6:0] half_reload(input logic [1:0] p,
	                                           input logic       x2);
		logic [7:0] div;
		div = 8'h00;
		unique case ({x2, p})
			3'b000: div = `SPMP_DIV_N0;
			3'b001: div = `SPMP_DIV_N1;
			3'b010: div = `SPMP_DIV_N2;
			3'b011: div = `SPMP_DIV_N3;
			3'b100: div = `SPMP_DIV_X0;
			3'b101: div = `SPMP_DIV_X1;
			3'b110: div = `SPMP_DIV_X2;
			3'b111: div = `SPMP_DIV_X3;
		endcase
		half_reload = 7'((div >> 1) - 8'h01);
	endfunction

	// ************************************************
	// Decoded controls
	// ************************************************
	logic       en;
	logic       mst;
	logic       order;
	logic       cpol;
	logic       cpha;
	logic [6:0] reload;
	logic       acc;
	logic       hit;
	logic [1:0] idx;
	logic       dacc;
	logic       stat_rd;
	logic       s_busy;
	logic       busy;
	logic       rise;
	logic       fall;
	logic       lead_e;
	logic       trail_e;

	assign en      = st_r.ctrl[`SPMP_B_EN];
	assign mst     = st_r.ctrl[`SPMP_B_MST];
	assign order   = st_r.ctrl[`SPMP_B_ORDER];
	assign cpol    = st_r.ctrl[`SPMP_B_CPOL];
	assign cpha    = st_r.ctrl[`SPMP_B_CPHA];
	assign reload  = half_reload(st_r.ctrl[1:0], st_r.ctrl[`SPMP_B_X2]);
	assign acc     = psel & penable;
	assign hit     = addr_hit(paddr);
	assign idx     = addr_idx(paddr);
	assign dacc    = acc & hit & (idx == `SPMP_IDX_DATA);
	assign stat_rd = acc & hit & ~pwrite & (idx == `SPMP_IDX_FLAGS);
	assign s_busy  = en & ~mst & ~ss_n_s
	                 & ((st_r.bitn != 3'h0) | st_r.lead);
	assign busy    = (st_r.st != SPMP_IDLE) | s_busy;
	assign rise    = sck_s & ~st_r.sck_d;
	assign fall    = ~sck_s & st_r.sck_d;
	// Leading edge is the rising one when the idle level is low
	assign lead_e  = cpol ? fall : rise;
	assign trail_e = cpol ? rise : fall;

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		logic       set_done;
		logic       set_wcol;
		logic       clr_done;
		logic       clr_wcol;
		logic       start;
		logic [7:0] sh_new;
		logic [7:0] rdv;
		st_nxt   = st_r;
		set_done = 1'b0;
		set_wcol = 1'b0;
		clr_done = 1'b0;
		clr_wcol = 1'b0;
		start    = 1'b0;
		sh_new   = st_r.sh;
		rdv      = 8'h00;
		st_nxt.sck_d = sck_s;

		// Read data is captured in the setup phase
		unique case (idx)
			`SPMP_IDX_CTRL:  rdv = st_r.ctrl;
			`SPMP_IDX_IRQ:   rdv = {6'h00, st_r.lvl};
			`SPMP_IDX_FLAGS: rdv = {st_r.done, st_r.wcol, 6'h00};
			`SPMP_IDX_DATA:  rdv = st_r.rxb;
		endcase
		if (psel & ~penable & ~pwrite) begin
			st_nxt.prdata = hit ? {24'h000000, rdv} : 32'h00000000;
		end

		if (acc & hit & pwrite & (idx == `SPMP_IDX_CTRL)) begin
			st_nxt.ctrl = pwdata[7:0];
		end
		if (acc & hit & pwrite & (idx == `SPMP_IDX_IRQ)) begin
			st_nxt.lvl = pwdata[1:0];
		end

		// Write to data register: load or collide
		if (dacc & pwrite) begin
			if (busy) begin
				set_wcol = 1'b1;
			end else if (en) begin
				st_nxt.sh = pwdata[7:0];
				start     = mst;
			end
		end

		// Master engine; divider only counts here
		unique case (st_r.st)
			SPMP_IDLE: begin
				if (start) begin
					st_nxt.st   = SPMP_LEAD;
					st_nxt.cnt  = reload;
					st_nxt.bitn = 3'h0;
					if (!cpha) begin
						st_nxt.mosi = tx_bit(pwdata[7:0], order);
					end
				end
			end
			SPMP_LEAD: begin
				if (st_r.cnt == 7'h00) begin
					st_nxt.sck = ~cpol;
					st_nxt.st  = SPMP_TRAIL;
					st_nxt.cnt = reload;
					if (!cpha) begin
						st_nxt.sh = shift_in(st_r.sh, miso_in, order);
					end else begin
						st_nxt.mosi = tx_bit(st_r.sh, order);
					end
				end else begin
					st_nxt.cnt = st_r.cnt - 7'h01;
				end
			end
			SPMP_TRAIL: begin
				if (st_r.cnt == 7'h00) begin
					st_nxt.sck = cpol;
					if (cpha) begin
						sh_new = shift_in(st_r.sh, miso_in, order);
					end
					st_nxt.sh = sh_new;
					if (st_r.bitn == `SPMP_LAST_BIT) begin
						// Clock stops after the eighth bit
						st_nxt.st  = SPMP_IDLE;
						st_nxt.rxb = sh_new;
						set_done   = 1'b1;
					end else begin
						st_nxt.bitn = st_r.bitn + 3'h1;
						st_nxt.st   = SPMP_LEAD;
						st_nxt.cnt  = reload;
						if (!cpha) begin
							st_nxt.mosi = tx_bit(sh_new, order);
						end
					end
				end else begin
					st_nxt.cnt = st_r.cnt - 7'h01;
				end
			end
			default: begin
				st_nxt.st = SPMP_IDLE;
			end
		endcase

		// Leaving master role or disabling aborts the byte
		if (!(en & mst)) begin
			st_nxt.st = SPMP_IDLE;
		end

		// Another master pulls select low
		if (en & mst & ss_pin_is_input & ~ss_n_s) begin
			st_nxt.ctrl[`SPMP_B_MST] = 1'b0;
			st_nxt.st = SPMP_IDLE;
			set_done  = 1'b1;
		end

		// Slave engine on synchronised pins
		if (en & ~mst) begin
			if (ss_n_s) begin
				// Partial byte never reaches the receive buffer
				st_nxt.bitn = 3'h0;
				st_nxt.lead = 1'b0;
			end else if (lead_e & ~st_r.lead) begin
				st_nxt.lead = 1'b1;
				if (!cpha) begin
					st_nxt.sh = shift_in(st_r.sh, mosi_s, order);
				end else begin
					st_nxt.miso = tx_bit(st_r.sh, order);
				end
			end else if (trail_e & st_r.lead) begin
				st_nxt.lead = 1'b0;
				if (cpha) begin
					sh_new = shift_in(st_r.sh, mosi_s, order);
				end
				st_nxt.sh = sh_new;
				if (!cpha) begin
					st_nxt.miso = tx_bit(sh_new, order);
				end
				if (st_r.bitn == `SPMP_LAST_BIT) begin
					st_nxt.bitn = 3'h0;
					st_nxt.rxb  = sh_new;
					set_done    = 1'b1;
				end else begin
					st_nxt.bitn = st_r.bitn + 3'h1;
				end
			end
			// First bit must stand before the first edge
			if (!cpha && (st_nxt.bitn == 3'h0) && !st_nxt.lead) begin
				st_nxt.miso = tx_bit(st_nxt.sh, order);
			end
		end else begin
			st_nxt.bitn = (st_nxt.st == SPMP_IDLE) ? 3'h0 : st_nxt.bitn;
			st_nxt.lead = 1'b0;
		end

		// Idle clock level follows the mode
		if (st_nxt.st == SPMP_IDLE) begin
			st_nxt.sck = st_nxt.ctrl[`SPMP_B_CPOL];
		end

		// Flags: a set in the same cycle beats any clear
		clr_done = irq_ack | (dacc & st_r.arm_done);
		clr_wcol = dacc & st_r.arm_wcol;
		st_nxt.done = set_done | (st_r.done & ~clr_done);
		st_nxt.wcol = set_wcol | (st_r.wcol & ~clr_wcol);
		st_nxt.arm_done = st_nxt.done & ~set_done & ~clr_done
		                  & (st_r.arm_done
		                     | (stat_rd & st_r.prdata[`SPMP_B_DONE]));
		st_nxt.arm_wcol = st_nxt.wcol & ~set_wcol & ~clr_wcol
		                  & (st_r.arm_wcol
		                     | (stat_rd & st_r.prdata[`SPMP_B_WCOL]));
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r       <= '0;
			st_r.ctrl  <= `SPMP_CTRL_RST;
			st_r.lvl   <= `SPMP_LVL_RST;
			st_r.sck_d <= 1'b1;
			st_r.st    <= SPMP_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	// Zero wait states; unmapped offsets answer with an error
	assign pready  = 1'b1;
	assign pslverr = acc & ~hit;
	assign prdata  = st_r.prdata;

	assign sck_out  = st_r.sck;
	assign mosi_out = st_r.mosi;
	assign miso_out = st_r.miso;
	// Select is never driven here; software owns it
	assign sck_oe   = en & mst & user_dir_sck;
	assign mosi_oe  = en & mst & user_dir_mosi;
	assign miso_oe  = en & ~mst & user_dir_miso & ~ss_n_s;

	assign irq_req   = st_r.done & (st_r.lvl != 2'h0);
	assign irq_level = st_r.lvl;

endmodule

// ===== pkg/spmp_consts.svh
// Purpose: constants of the serial port block
// Assumes: included by bare name
// Notes:   register indices; byte address is four times the index
`ifndef SPMP_CONSTS_SVH
`define SPMP_CONSTS_SVH

// ************************************************
// Register indices
// ************************************************
`define SPMP_IDX_CTRL   2'h0
`define SPMP_IDX_IRQ    2'h1
`define SPMP_IDX_FLAGS  2'h2
`define SPMP_IDX_DATA   2'h3

// ************************************************
// Field positions
// ************************************************
`define SPMP_B_X2       7
`define SPMP_B_EN       6
`define SPMP_B_ORDER    5
`define SPMP_B_MST      4
`define SPMP_B_CPOL     3
`define SPMP_B_CPHA     2
`define SPMP_B_DONE     7
`define SPMP_B_WCOL     6

// ************************************************
// Reset values
// ************************************************
`define SPMP_CTRL_RST   8'h00
`define SPMP_LVL_RST    2'h0

// ************************************************
// Clock divisors, normal and double speed; last bit index
// ************************************************
`define SPMP_DIV_N0     8'h04
`define SPMP_DIV_N1     8'h10
`define SPMP_DIV_N2     8'h40
`define SPMP_DIV_N3     8'h80
`define SPMP_DIV_X0     8'h02
`define SPMP_DIV_X1     8'h08
`define SPMP_DIV_X2     8'h20
`define SPMP_DIV_X3     8'h40
`define SPMP_LAST_BIT   3'h7

`endif

// ===== pkg/spmp_pkg.sv
// Purpose: types of the serial port block
// Assumes: nothing
// Notes:   state of the top module is one packed struct
package spmp_pkg;

	typedef enum logic [1:0] {
		SPMP_IDLE  = 2'b00,
		SPMP_LEAD  = 2'b01,
		SPMP_TRAIL = 2'b11
	} spmp_st_e;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [1:0]  lvl;
		logic        done;
		logic        wcol;
		logic        arm_done;
		logic        arm_wcol;
		logic [7:0]  sh;
		logic [7:0]  rxb;
		logic [2:0]  bitn;
		logic        lead;
		spmp_st_e    st;
		logic [6:0]  cnt;
		logic        sck;
		logic        mosi;
		logic        miso;
		logic        sck_d;
		logic [31:0] prdata;
	} spmp_state_s;

endpackage

// ===== src/spmp_sync.sv
// Purpose: two-stage synchroniser for a group of levels
// Assumes: inputs may change at any time
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module spmp_sync #(
	parameter int W = 3
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} spmp_sync_s;

	spmp_sync_s sy_r;
	spmp_sync_s sy_nxt;

	always_comb begin
		sy_nxt    = sy_r;
		sy_nxt.s1 = d;
		sy_nxt.s2 = sy_r.s1;
	end

	// Resets high: idle select and idle clock read as released
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sy_r <= '1;
		end else begin
			sy_r <= sy_nxt;
		end
	end

	assign q = sy_r.s2;
endmodule

// ===== tb/spmp_checker.sv
// Purpose: port checks of the serial block
// Assumes: bound to spmp_top
// Notes:   sees top ports only
`timescale 1ns/100ps
module spmp_checker #(
	parameter int AW = 4
) (
	input wire logic          core_clk,
	input wire logic          resetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0]   prdata,
	input wire logic          sck_oe,
	input wire logic          mosi_oe,
	input wire logic          miso_oe,
	input wire logic          ss_n_in,
	input wire logic          ss_pin_is_input,
	input wire logic          user_dir_sck,
	input wire logic          user_dir_mosi,
	input wire logic          irq_ack,
	input wire logic          irq_req,
	input wire logic [1:0]    irq_level
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire acc = psel && penable;
	sequence s_master;
		sck_oe && ss_pin_is_input && $fell(ss_n_in);
	endsequence
	sequence s_held_low;
		(ss_pin_is_input && !ss_n_in) [*3];
	endsequence
	AST_FLAGS_ZERO: assert property (acc && !pwrite && paddr == 4'h8
		|-> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h000000)
		else $error("status reserved bits not zero");
	AST_IRQ_LVL: assert property (irq_req |-> irq_level != 2'h0)
		else $error("request with level zero");
	AST_IRQ_ACK: assert property (irq_ack |=> !irq_req)
		else $error("request kept after ack");
	AST_MISO_OFF: assert property (
		ss_n_in && $past(ss_n_in) && $past(ss_n_in, 2) |-> !miso_oe)
		else $error("miso driven while unselected");
	AST_OE_ROLE: assert property (miso_oe |-> !sck_oe && !mosi_oe)
		else $error("both roles drive");
	AST_SCK_DIR: assert property (sck_oe |-> user_dir_sck)
		else $error("clock driven against direction");
	AST_MOSI_DIR: assert property (mosi_oe |-> user_dir_mosi)
		else $error("data out driven against direction");
	AST_FAULT: assert property (s_master ##1 s_held_low
		|-> ##[0:2] !sck_oe)
		else $error("master kept after select low");
endmodule

bind spmp_top spmp_checker #(.AW(AW)) i_chk (
	.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.sck_oe, .mosi_oe, .miso_oe, .ss_n_in, .ss_pin_is_input,
	.user_dir_sck, .user_dir_mosi, .irq_ack, .irq_req, .irq_level
);

// ===== tb/spmp_slave_model.sv
// Purpose: far side serial slave, all four modes
// Assumes: selected by bench, msb first
// Notes:   unselected output shows inverse of last bit
`timescale 1ns/100ps
module spmp_slave_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	input  wire logic [1:0] mode,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic [7:0]      rx_byte
);
	// ****
	// Shifter
	// ****
	logic [7:0] sh = 8'h00;
	logic       q  = 1'b0;
	int         ns = 0;
	always @(negedge ss_n) begin
		sh = tx_byte;
		ns = 0;
	end
	// Sample when leading matches phase 0, else setup
	always @(sck) begin
		if (!ss_n && ((sck != mode[1]) ^ mode[0])) begin
			rx_byte = {rx_byte[6:0], mosi};
			ns++;
		end else if (!ss_n && ns > 0) begin
			sh = sh << 1;
		end
	end
	always @(sh or ss_n) begin
		if (!ss_n)
			q = sh[7];
	end
	// Released line must not look valid
	assign miso = ss_n ? ~q : sh[7];
endmodule

// ===== tb/spi_master_slave_port_test.sv
// Purpose: register level test of the serial block
// Assumes: APB with zero wait, one clock
// Notes:   far side slave model for master transfers
`timescale 1ns/100ps
module spi_master_slave_port_test;
	logic        core_clk, resetn, psel, penable, pwrite;
	logic [3:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, sck_in, sck_out, sck_oe, mosi_in;
	logic        mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
	logic        ss_n_in, ss_pin_is_input, user_dir_sck, user_dir_mosi;
	logic        user_dir_miso, irq_ack, irq_req, e, ms_ss_n;
	logic [1:0]  irq_level, md;
	logic [7:0]  mtx, mrx, d;
	int          error_cnt, samples_checked, c;
	int          dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

	spmp_top i_dut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sck_in, .sck_out, .sck_oe,
		.mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
		.ss_n_in, .ss_pin_is_input, .user_dir_sck, .user_dir_mosi,
		.user_dir_miso, .irq_ack, .irq_req, .irq_level);
	spmp_slave_model i_far (.sck(sck_out), .mosi(mosi_out), .ss_n(ms_ss_n),
		.mode(md), .tx_byte(mtx), .miso(miso_in), .rx_byte(mrx));

	// ****
	// Tasks
	// ****
	function automatic logic [7:0] rev(input logic [7:0] v);
		rev = {<<{v}};
	endfunction
	task wrap_up;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			wrap_up;
		end
	endtask
	task wait_irq;
		c = 0;
		while (irq_req !== 1'b1 && c < 3000) begin
			@(posedge core_clk);
			c++;
		end
		if (c >= 3000) begin
			error_cnt++;
			wrap_up;
		end
	endtask
	task ack;
		irq_ack <= 1'b1;
		@(posedge core_clk);
		irq_ack <= 1'b0;
	endtask
	// Phases of six cycles keep clear of the sampling limit
	task sbyte(input logic [7:0] v, input int n, input logic [1:0] m);
		d = 8'h00;
		for (int b = 0; b < n; b++) begin
			if (!m[0])
				mosi_in <= v[7-b];
			repeat (6) @(posedge core_clk);
			if (!m[0])
				d[7-b] = miso_out;
			sck_in <= ~m[1];
			if (m[0])
				mosi_in <= v[7-b];
			repeat (6) @(posedge core_clk);
			if (m[0])
				d[7-b] = miso_out;
			sck_in <= m[1];
		end
		repeat (6) @(posedge core_clk);
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, sck_in, mosi_in} = '0;
		{irq_ack, md, mtx, resetn, error_cnt, samples_checked} = '0;
		{ss_n_in, ms_ss_n, ss_pin_is_input} = 3'h7;
		{user_dir_sck, user_dir_mosi, user_dir_miso} = 3'h7;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		apb(0, 4'h0, 0); chk(r, 32'h00);
		apb(0, 4'h8, 0); chk(r, 32'h00);
		apb(0, 4'h5, 0); chk(r, 32'h00);
		chk({31'h0, e}, 32'h1);
		apb(1, 4'h4, 32'h01);
		for (int i = 0; i < 8; i++) begin
			mtx <= 8'(8'hC3 ^ i);
			md <= i[1:0];
			apb(1, 4'h0, {24'h0, i[2], 1'b1, i[2], 1'b1, i[1:0], i[1:0]});
			repeat (2) @(posedge core_clk);
			chk(sck_out, i[1]);
			ms_ss_n <= 1'b0;
			d = 8'(8'h5A + i);
			apb(1, 4'hC, d);
			wait_irq;
			chk(c >= 8 * dv[i] - 2 && c <= 8 * dv[i] + 3, 1);
			apb(0, 4'h8, 0); chk(r, 32'h80);
			ack;
			ms_ss_n <= 1'b1;
			apb(0, 4'hC, 0); chk(r, i[2] ? rev(mtx) : mtx);
			chk(mrx, i[2] ? rev(d) : d);
		end
		mtx <= 8'h11;
		md <= 2'h0;
		apb(1, 4'h0, 32'h50);
		ms_ss_n <= 1'b0;
		apb(1, 4'hC, 32'h81);
		apb(1, 4'hC, 32'h7E);
		wait_irq;
		apb(0, 4'h8, 0); chk(r, 32'hC0);
		apb(0, 4'hC, 0); chk(r, 32'h11);
		apb(0, 4'h8, 0); chk(r, 32'h00);
		chk(mrx, 8'h81);
		ms_ss_n <= 1'b1;
		apb(1, 4'h0, 32'h10);
		apb(1, 4'hC, 32'hFF);
		repeat (40) @(posedge core_clk);
		chk(sck_oe, 0);
		apb(0, 4'h8, 0); chk(r, 32'h00);
		apb(1, 4'h0, 32'h50);
		ss_n_in <= 1'b0;
		repeat (6) @(posedge core_clk);
		apb(0, 4'h0, 0); chk(r, 32'h40);
		apb(0, 4'h8, 0); chk(r, 32'h80);
		apb(1, 4'h4, 0);
		@(posedge core_clk);
		chk(irq_req, 0);
		chk(irq_level, 2'h0);
		apb(1, 4'h4, 32'h01);
		@(posedge core_clk);
		chk(irq_req, 1);
		chk(irq_level, 2'h1);
		ss_n_in <= 1'b1;
		ack;
		apb(1, 4'h0, 32'hC3);
		apb(1, 4'hC, 32'h96);
		repeat (4) @(posedge core_clk);
		chk(miso_oe, 0);
		ss_n_in <= 1'b0;
		repeat (6) @(posedge core_clk);
		sbyte(8'h3C, 8, 2'h0); chk(d, 8'h96);
		apb(0, 4'h8, 0); chk(r, 32'h80);
		apb(0, 4'hC, 0); chk(r, 32'h3C);
		sbyte(8'hF0, 3, 2'h0);
		ss_n_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		ss_n_in <= 1'b0;
		repeat (6) @(posedge core_clk);
		sbyte(8'hA5, 8, 2'h0);
		apb(0, 4'hC, 0); chk(r, 32'hA5);
		ss_n_in <= 1'b1;
		ack;
		// Slave in mode 3, LSB first: idle clock high, setup on leading
		apb(1, 4'h0, 32'h6C);
		sck_in <= 1'b1;
		apb(1, 4'hC, 32'h96);
		ss_n_in <= 1'b0;
		repeat (6) @(posedge core_clk);
		sbyte(8'h1E, 8, 2'h3); chk(d, 8'h69);
		apb(0, 4'hC, 0); chk(r, 32'h78);
		ss_n_in <= 1'b1;
		wrap_up;
	end
endmodule
